// File: dlt_consts.svh
// Constants for the DAC load and thermal output control block.
// Assumes it is included by bare name from the design and bench files.
`ifndef DLT_CONSTS_SVH
`define DLT_CONSTS_SVH

// ****************************************************************
// Register addresses
// ****************************************************************
`define DLT_ADDR_DAC_A 8'h10
`define DLT_ADDR_DAC_B 8'h11
`define DLT_ADDR_DAC_C 8'h12
`define DLT_ADDR_DAC_D 8'h13
`define DLT_ADDR_MEAS 8'h19
`define DLT_ADDR_CONV 8'h1A
`define DLT_ADDR_DCFG 8'h1B
`define DLT_ADDR_LOAD 8'h1C
`define DLT_ADDR_OFS_INT 8'h21
`define DLT_ADDR_OFS_EXT 8'h22

// ****************************************************************
// Field positions
// ****************************************************************
`define DLT_BIT_AVG_OFF 5
`define DLT_BIT_FAST 0
`define DLT_BIT_LOAD_SRC 3
`define DLT_BIT_ADC_REF 4
`define DLT_BIT_THERM_A 5
`define DLT_BIT_THERM_B 6
`define DLT_BIT_SPAN_A 0
`define DLT_BIT_SPAN_B 1
`define DLT_BIT_LD_LO 4
`define DLT_BIT_LD_HI 5
`define DLT_BIT_REF_INT 4

// ****************************************************************
// Reset values, masks and counts
// ****************************************************************
`define DLT_RST_OPT 8'h00
`define DLT_RST_OFS 8'hD8
`define DLT_RST_CODE 8'h00
`define DLT_MASK_AB 4'h3
`define DLT_MASK_CD 4'hC
`define DLT_MASK_ALL 4'hF
`define DLT_AVG_ON 5'h10
`define DLT_AVG_OFF 5'h01
`define DLT_CODE_MAX 10'h0FF
`define DLT_CAL_TIME_US 5000
`define DLT_CLK_MHZ 100
`define DLT_CAL_CNT_W 20

`endif

// File: dlt_dac_load_thermal.sv
// DAC code staging, load sources, thermal output and converter settings.
// Assumes a serial front end on clk presents register reads and writes,
// and the measurement logic on clk pulses each temperature result.
`timescale 1ns/100ps
`include "dlt_consts.svh"

// Notes on behaviour
// - fast bit raises converter clock; slow after reset
// - fast clock switches remote input filter off
// - average sixteen by default; disable bit gives one
// - written code pending until a load command
// - DAC read returns the code driving output
// - load from pin fall, config bits, load register
// - strobe held low; must rise before next load
// - codes are 8-bit straight binary, 0 to 255
// - reference select held; external after reset
// - per-DAC gain bit: zero unity, one double
// - two bits enable thermal mode on A, B
// - thermal DAC follows each temperature result
// - one degree equals one code step
// - span bits double thermal output span
// - range -128..127; code zero is -40 default
// - signed offset register per sensor sets zero
// - calibrate after power-up; traffic interrupts it
// - after calibration idle, all DAC codes zero
// - load source bit moves control to registers
module dlt_dac_load_thermal #(
  parameter int unsigned CAL_CYCLES = `DLT_CAL_TIME_US * `DLT_CLK_MHZ
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire dlt_pkg::dlt_byte_t reg_addr,
  input wire dlt_pkg::dlt_byte_t reg_wdata,
  output dlt_pkg::dlt_byte_t reg_rdata,
  output logic reg_rdata_valid,
  input wire logic dac_load_strobe_n,
  input wire logic temp_int_valid,
  input wire dlt_pkg::dlt_temp_t temp_int,
  input wire logic temp_ext_valid,
  input wire dlt_pkg::dlt_temp_t temp_ext,
  output dlt_pkg::dlt_codes_t dac_code,
  output logic [3:0] dac_gain_x2,
  output logic dac_ref_internal,
  output logic adc_clock_fast,
  output logic remote_filter_enable,
  output logic adc_ref_vdd,
  output logic [4:0] average_count,
  output logic cal_busy,
  output logic cal_interrupted
);
  import dlt_pkg::*;

  // ****************************************************************
  // Functions
  // ****************************************************************

  // Temperature in quarter degrees to a saturated thermal DAC code
  function automatic dlt_byte_t therm_code(input dlt_temp_t t,
                                           input dlt_byte_t ofs);
    logic signed [9:0] deg;
    logic signed [9:0] diff;
    deg = $signed(t) >>> 2;
    diff = deg - $signed({{2{ofs[7]}}, ofs});
    if (diff < 0) begin
      therm_code = `DLT_RST_CODE;
    end else if (diff > $signed(`DLT_CODE_MAX)) begin
      therm_code = dlt_byte_t'(`DLT_CODE_MAX);
    end else begin
      therm_code = diff[7:0];
    end
  endfunction

  // ****************************************************************
  // Storage
  // ****************************************************************
  dlt_byte_t meas_options;
  dlt_byte_t converter_options;
  dlt_byte_t dac_gain_span_load;
  logic ref_internal;
  dlt_byte_t internal_thermal_offset;
  dlt_byte_t remote_thermal_offset;
  dlt_codes_t pending;
  logic strobe_s1;
  logic strobe_s2;
  logic strobe_s3;
  dlt_cal_state_t cal_state;
  logic [`DLT_CAL_CNT_W-1:0] cal_cnt;

  localparam logic [`DLT_CAL_CNT_W-1:0] CAL_LAST =
    `DLT_CAL_CNT_W'(CAL_CYCLES - 1);

  // ****************************************************************
  // Decode
  // ****************************************************************

  // Write strobes per register
  wire wr_meas = reg_wr && (reg_addr == `DLT_ADDR_MEAS);
  wire wr_conv = reg_wr && (reg_addr == `DLT_ADDR_CONV);
  wire wr_dcfg = reg_wr && (reg_addr == `DLT_ADDR_DCFG);
  wire wr_load = reg_wr && (reg_addr == `DLT_ADDR_LOAD);
  wire wr_ofs_int = reg_wr && (reg_addr == `DLT_ADDR_OFS_INT);
  wire wr_ofs_ext = reg_wr && (reg_addr == `DLT_ADDR_OFS_EXT);
  wire [3:0] wr_dac;
  assign wr_dac[0] = reg_wr && (reg_addr == `DLT_ADDR_DAC_A);
  assign wr_dac[1] = reg_wr && (reg_addr == `DLT_ADDR_DAC_B);
  assign wr_dac[2] = reg_wr && (reg_addr == `DLT_ADDR_DAC_C);
  assign wr_dac[3] = reg_wr && (reg_addr == `DLT_ADDR_DAC_D);

  // Mode bits
  wire load_source_select = converter_options[`DLT_BIT_LOAD_SRC];
  wire therm_a = converter_options[`DLT_BIT_THERM_A];
  wire therm_b = converter_options[`DLT_BIT_THERM_B];
  wire register_load_ctl_lo = reg_wdata[`DLT_BIT_LD_LO];
  wire register_load_ctl_hi = reg_wdata[`DLT_BIT_LD_HI];

  // Falling edge seen on the synchronised strobe only
  wire pin_fall = strobe_s3 && !strobe_s2;

  // Three load sources, chosen by the load source bit
  wire [3:0] pin_load = (pin_fall && !load_source_select) ?
    `DLT_MASK_ALL : 4'h0;
  wire [3:0] cfg_load = (wr_dcfg && load_source_select) ?
    ((register_load_ctl_lo ? `DLT_MASK_AB : 4'h0) |
     (register_load_ctl_hi ? `DLT_MASK_CD : 4'h0)) : 4'h0;
  wire [3:0] ldreg_load = (wr_load && load_source_select) ?
    reg_wdata[3:0] : 4'h0;
  wire [3:0] load_mask = pin_load | cfg_load | ldreg_load;

  // Thermal updates replace loads on A and B
  wire therm_upd_a = therm_a && temp_int_valid;
  wire therm_upd_b = therm_b && temp_ext_valid;
  wire [3:0] therm_own = {2'b00, therm_b, therm_a};
  wire dlt_byte_t therm_a_code = therm_code(temp_int,
                                            internal_thermal_offset);
  wire dlt_byte_t therm_b_code = therm_code(temp_ext,
                                            remote_thermal_offset);

  // Read selection; DAC reads show the driving code
  wire dlt_byte_t next_rdata =
    (reg_addr == `DLT_ADDR_DAC_A) ? dac_code[0] :
    (reg_addr == `DLT_ADDR_DAC_B) ? dac_code[1] :
    (reg_addr == `DLT_ADDR_DAC_C) ? dac_code[2] :
    (reg_addr == `DLT_ADDR_DAC_D) ? dac_code[3] :
    (reg_addr == `DLT_ADDR_MEAS) ? meas_options :
    (reg_addr == `DLT_ADDR_CONV) ? converter_options :
    (reg_addr == `DLT_ADDR_DCFG) ? dac_gain_span_load :
    (reg_addr == `DLT_ADDR_LOAD) ?
      dlt_byte_t'({ref_internal, 4'h0}) :
    (reg_addr == `DLT_ADDR_OFS_INT) ? internal_thermal_offset :
    (reg_addr == `DLT_ADDR_OFS_EXT) ? remote_thermal_offset :
    8'h00;

  // ****************************************************************
  // Outputs from settings
  // ****************************************************************

  // Converter settings
  assign adc_clock_fast = converter_options[`DLT_BIT_FAST];
  assign remote_filter_enable = !adc_clock_fast;
  assign adc_ref_vdd = converter_options[`DLT_BIT_ADC_REF];
  assign average_count = meas_options[`DLT_BIT_AVG_OFF] ?
    `DLT_AVG_OFF : `DLT_AVG_ON;
  assign dac_ref_internal = ref_internal;
  // Gain bits double DAC span, thermal span included
  assign dac_gain_x2 = dac_gain_span_load[3:0];
  assign cal_busy = (cal_state == DLT_CAL_RUN);

  // ****************************************************************
  // Registers
  // ****************************************************************

  // Settings registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meas_options <= `DLT_RST_OPT;
      converter_options <= `DLT_RST_OPT;
      dac_gain_span_load <= `DLT_RST_OPT;
      ref_internal <= 1'b0;
      internal_thermal_offset <= `DLT_RST_OFS;
      remote_thermal_offset <= `DLT_RST_OFS;
    end else begin
      if (wr_meas) meas_options <= reg_wdata;
      if (wr_conv) converter_options <= reg_wdata;
      if (wr_dcfg) dac_gain_span_load <= reg_wdata;
      if (wr_load) ref_internal <= reg_wdata[`DLT_BIT_REF_INT];
      if (wr_ofs_int) internal_thermal_offset <= reg_wdata;
      if (wr_ofs_ext) remote_thermal_offset <= reg_wdata;
    end
  end

  // Strobe synchroniser and edge history
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      strobe_s1 <= 1'b1;
      strobe_s2 <= 1'b1;
      strobe_s3 <= 1'b1;
    end else begin
      strobe_s1 <= dac_load_strobe_n;
      strobe_s2 <= strobe_s1;
      strobe_s3 <= strobe_s2;
    end
  end

  // Pending codes, one per DAC
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pending <= '0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (wr_dac[i]) pending[i] <= reg_wdata;
      end
    end
  end

  // Driving codes: load copies pending, thermal tracks temperature
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dac_code <= '0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (load_mask[i] && !therm_own[i]) begin
          dac_code[i] <= pending[i];
        end
      end
      if (therm_upd_a) dac_code[0] <= therm_a_code;
      if (therm_upd_b) dac_code[1] <= therm_b_code;
    end
  end

  // Registered read answer
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
      reg_rdata_valid <= 1'b0;
    end else begin
      reg_rdata_valid <= reg_rd;
      if (reg_rd) reg_rdata <= next_rdata;
    end
  end

  // Power-up calibration, cut short by any serial access
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cal_state <= DLT_CAL_RUN;
      cal_cnt <= '0;
      cal_interrupted <= 1'b0;
    end else begin
      case (cal_state)
        DLT_CAL_RUN: begin
          cal_cnt <= cal_cnt + 1'b1;
          if (reg_wr || reg_rd) begin
            cal_state <= DLT_CAL_IDLE;
            cal_interrupted <= 1'b1;
          end else if (cal_cnt == CAL_LAST) begin
            cal_state <= DLT_CAL_IDLE;
          end
        end
        default: begin
          cal_state <= DLT_CAL_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking dlt_cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // Staging, reads and strobe
  a_pending_held: assert property (
    (wr_dac[0] && !load_mask[0] && !therm_upd_a) |=>
      dac_code[0] == $past(dac_code[0]))
    else $error("DAC A changed without a load");
  a_read_current: assert property (
    (reg_rd && reg_addr == `DLT_ADDR_DAC_B) |=>
      reg_rdata_valid && reg_rdata == $past(dac_code[1]))
    else $error("DAC B read did not show driving code");
  a_pin_load: assert property (
    (strobe_s2 ##1 !strobe_s2 && !load_source_select && !therm_own[2])
      |=> dac_code[2] == $past(pending[2]))
    else $error("Strobe fall did not load DAC C");
  a_strobe_once: assert property (
    pin_fall |=> !pin_fall)
    else $error("One strobe fall loaded twice");

  // Load sources and their selection
  a_strobe_ignored: assert property (
    (pin_fall && load_source_select && !wr_dcfg && !wr_load &&
     !therm_upd_a && !therm_upd_b) |=> dac_code == $past(dac_code))
    else $error("Strobe loaded while registers own the load");
  a_reg_load_d: assert property (
    (wr_load && load_source_select && reg_wdata[3]) |=>
      dac_code[3] == $past(pending[3]))
    else $error("Load register did not load DAC D");

  // Settings and calibration
  a_gain_bits: assert property (
    wr_dcfg |=> dac_gain_x2 == $past(reg_wdata[3:0]))
    else $error("Gain bits not taken from configuration write");
  a_ref_select: assert property (
    wr_load |=> dac_ref_internal == $past(reg_wdata[`DLT_BIT_REF_INT]))
    else $error("Reference select not taken from load write");
  a_idle_zero: assert property (
    ($fell(cal_busy) && !cal_interrupted) |-> dac_code == '0)
    else $error("DAC codes not zero after calibration");

  // Converter and thermal settings, calibration abort
  a_fast_filter: assert property (
    (wr_conv && reg_wdata[`DLT_BIT_FAST]) |=>
      adc_clock_fast && !remote_filter_enable)
    else $error("Fast clock left filter on");
  a_avg_count: assert property (
    wr_meas |=> average_count ==
      ($past(reg_wdata[`DLT_BIT_AVG_OFF]) ? `DLT_AVG_OFF : `DLT_AVG_ON))
    else $error("Averaging count wrong");
  a_therm_zero: assert property (
    (therm_upd_a && temp_int == {internal_thermal_offset, 2'b00})
      |=> dac_code[0] == 8'h00)
    else $error("Offset temperature did not give code zero");
  a_therm_step: assert property (
    (therm_upd_b && therm_b_code != 8'hFF && therm_b_code != 8'h00 &&
     $signed(temp_ext) < $signed(10'h1FC) &&
     therm_code(temp_ext + 10'h004, remote_thermal_offset) != 8'hFF)
      |-> therm_code(temp_ext + 10'h004, remote_thermal_offset) ==
          therm_b_code + 8'h01)
    else $error("One degree is not one code step");
  a_cal_abort: assert property (
    (cal_busy && (reg_wr || reg_rd)) |=> !cal_busy && cal_interrupted)
    else $error("Access did not end calibration");

  // Main scenarios reached
  c_pin_load: cover property (pin_fall && !load_source_select);
  c_therm_a: cover property (therm_upd_a);
  c_therm_b: cover property (therm_upd_b);
  c_cal_done: cover property (cal_busy ##1 !cal_busy && !cal_interrupted);
  c_reg_load: cover property (ldreg_load != 4'h0);

endmodule // dlt_dac_load_thermal

// File: dlt_dac_load_thermal_bench.sv
// Self-checking bench for the DAC load and thermal output block.
// Assumes dlt_pkg, dlt_consts.svh and dlt_host_model are compiled first.
`timescale 1ns/100ps
`include "dlt_consts.svh"
module dlt_dac_load_thermal_bench;
  import dlt_pkg::*;

  // ****************************************************************
  // Signals
  // ****************************************************************
  localparam int unsigned CAL = 20;
  logic clk, resetn, reg_wr, reg_rd, dac_load_strobe_n, reg_rdata_valid;
  logic temp_int_valid, temp_ext_valid, dac_ref_internal, adc_clock_fast;
  logic remote_filter_enable, adc_ref_vdd, cal_busy, cal_interrupted;
  dlt_byte_t reg_addr, reg_wdata, reg_rdata, x;
  dlt_temp_t temp_int, temp_ext, tr;
  dlt_codes_t dac_code, codes;
  logic [3:0] dac_gain_x2;
  logic [4:0] average_count;
  dlt_byte_t exp_q[$];
  int n_mismatch, check_count, cycles, seed, td;

  dlt_dac_load_thermal #(.CAL_CYCLES(CAL)) DUT (.clk(clk), .resetn(resetn),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rdata_valid(reg_rdata_valid), .dac_load_strobe_n(dac_load_strobe_n),
    .temp_int_valid(temp_int_valid), .temp_int(temp_int),
    .temp_ext_valid(temp_ext_valid), .temp_ext(temp_ext),
    .dac_code(dac_code), .dac_gain_x2(dac_gain_x2),
    .dac_ref_internal(dac_ref_internal), .adc_clock_fast(adc_clock_fast),
    .remote_filter_enable(remote_filter_enable), .adc_ref_vdd(adc_ref_vdd),
    .average_count(average_count), .cal_busy(cal_busy),
    .cal_interrupted(cal_interrupted));

  dlt_host_model host (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .dac_load_strobe_n(dac_load_strobe_n));

  // ****************************************************************
  // Clock, timeout and checking
  // ****************************************************************
  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Cut a hang short
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      n_mismatch++;
      summarize();
    end
  end

  // Compare one value and count it
  task automatic check(input string n, input logic [31:0] e,
                       input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %0h seen %0h", n, e, g);
    end
  endtask

  // Each read answer is matched with the oldest expected byte
  always @(negedge clk) begin
    if (reg_rdata_valid === 1'b1) begin
      if (exp_q.size() == 0) check("read_count", 0, 1);
      else check("reg_rdata", exp_q.pop_front(), reg_rdata);
    end
  end

  // Register write, effects settle by the next falling edge
  task automatic wr(input dlt_byte_t a, input dlt_byte_t d);
    host.access(1'b1, a, d);
    @(negedge clk);
  endtask

  // Register read with the expected byte noted
  task automatic rd(input dlt_byte_t a, input dlt_byte_t e);
    exp_q.push_back(e);
    host.access(1'b0, a, 8'h00);
  endtask

  // Compare the driving codes
  task automatic cc();
    @(negedge clk);
    check("dac_code", codes, dac_code);
  endtask

  // Present one temperature result and compare the thermal code
  task automatic th(input logic ext, input dlt_temp_t t, input dlt_byte_t e);
    @(posedge clk);
    temp_int_valid <= ~ext;
    temp_ext_valid <= ext;
    temp_int <= t;
    temp_ext <= t;
    @(posedge clk);
    temp_int_valid <= 1'b0;
    temp_ext_valid <= 1'b0;
    @(negedge clk);
    check("thermal_code", e, dac_code[ext]);
  endtask

  // Print the counts and the verdict, then stop
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    seed = 32'h0000AD69;
    resetn = 1'b0;
    temp_int_valid = 1'b0;
    temp_ext_valid = 1'b0;
    temp_int = 10'h000;
    temp_ext = 10'h000;
    codes = 32'h00000000;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    cc();
    check("fast", 0, adc_clock_fast);
    check("filter", 1, remote_filter_enable);
    check("average", 16, average_count);
    check("ref_int", 0, dac_ref_internal);
    check("cal_busy", 1, cal_busy);
    repeat (CAL + 5) @(posedge clk);
    @(negedge clk);
    check("cal_busy", 0, cal_busy);
    check("cal_intr", 0, cal_interrupted);
    rd(`DLT_ADDR_OFS_INT, 8'hD8);
    rd(`DLT_ADDR_OFS_EXT, 8'hD8);
    rd(8'h30, 8'h00);
    $display("reset test done");
    // Converter clock, filter and averaging
    wr(`DLT_ADDR_CONV, 8'h11);
    check("fast", 1, adc_clock_fast);
    check("filter", 0, remote_filter_enable);
    check("adc_ref", 1, adc_ref_vdd);
    wr(`DLT_ADDR_MEAS, 8'h20);
    check("average", 1, average_count);
    rd(`DLT_ADDR_CONV, 8'h11);
    wr(`DLT_ADDR_CONV, 8'h00);
    check("filter", 1, remote_filter_enable);
    check("adc_ref", 0, adc_ref_vdd);
    $display("converter test done");
    // Pending codes, strobe loads once per fall
    for (int i = 0; i < 4; i++) begin
      codes[i] = 8'($random(seed));
      wr(`DLT_ADDR_DAC_A + 8'(i), codes[i]);
    end
    check("dac_code", 0, dac_code);
    rd(`DLT_ADDR_DAC_A, 8'h00);
    host.strobe(1'b0);
    host.strobe(1'b1);
    cc();
    rd(`DLT_ADDR_DAC_B, codes[1]);
    host.strobe(1'b0);
    wr(`DLT_ADDR_DAC_C, ~codes[2]);
    repeat (5) @(posedge clk);
    cc();
    host.strobe(1'b1);
    host.strobe(1'b0);
    host.strobe(1'b1);
    codes[2] = ~codes[2];
    cc();
    $display("strobe test done");
    // Register loads, gain and reference
    wr(`DLT_ADDR_CONV, 8'h08);
    x = 8'($random(seed));
    wr(`DLT_ADDR_DAC_A, x);
    wr(`DLT_ADDR_DAC_D, ~x);
    host.strobe(1'b0);
    host.strobe(1'b1);
    cc();
    wr(`DLT_ADDR_LOAD, 8'h01);
    codes[0] = x;
    cc();
    wr(`DLT_ADDR_LOAD, 8'h18);
    codes[3] = ~x;
    cc();
    check("ref_int", 1, dac_ref_internal);
    rd(`DLT_ADDR_LOAD, 8'h10);
    wr(`DLT_ADDR_DAC_C, x ^ 8'h5A);
    wr(`DLT_ADDR_DCFG, 8'h25);
    codes[2] = x ^ 8'h5A;
    cc();
    check("gain", 4'h5, dac_gain_x2);
    wr(`DLT_ADDR_DAC_B, 8'hFF);
    wr(`DLT_ADDR_DCFG, 8'h1A);
    codes[1] = 8'hFF;
    cc();
    check("gain", 4'hA, dac_gain_x2);
    $display("register load test done");
    // Thermal tracking, floor, offsets and clamping
    wr(`DLT_ADDR_CONV, 8'h68);
    th(1'b0, 10'h067, 8'h41);
    th(1'b0, 10'h068, 8'h42);
    th(1'b1, 10'h3F6, 8'h25);
    // Random reading on a random sensor, both offsets still at -40
    tr = 10'($random(seed));
    x = 8'($random(seed));
    td = ($signed(tr) >>> 2) + 40;
    th(x[0], tr, 8'((td < 0) ? 0 : td));
    wr(`DLT_ADDR_OFS_INT, 8'h0A);
    th(1'b0, 10'h014, 8'h00);
    th(1'b0, 10'h028, 8'h00);
    th(1'b0, 10'h064, 8'h0F);
    wr(`DLT_ADDR_OFS_INT, 8'h80);
    th(1'b0, 10'h1FF, 8'hFF);
    wr(`DLT_ADDR_DCFG, 8'h03);
    check("span", 4'h3, dac_gain_x2);
    $display("thermal test done");
    // Early traffic cuts calibration short
    @(posedge clk);
    resetn <= 1'b0;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    codes = 32'h00000000;
    rd(`DLT_ADDR_MEAS, 8'h00);
    @(negedge clk);
    check("cal_busy", 0, cal_busy);
    check("cal_intr", 1, cal_interrupted);
    cc();
    repeat (3) @(posedge clk);
    check("reads_left", 0, exp_q.size());
    $display("calibration test done");
    summarize();
  end
endmodule // dlt_dac_load_thermal_bench

// File: dlt_host_model.sv
// Host model: drives the register port and the load strobe pin.
// Assumes the bench calls its tasks and that it shares the block's clock.
`timescale 1ns/100ps
module dlt_host_model (
  input wire logic clk,
  output logic reg_wr,
  output logic reg_rd,
  output dlt_pkg::dlt_byte_t reg_addr,
  output dlt_pkg::dlt_byte_t reg_wdata,
  output logic dac_load_strobe_n
);
  import dlt_pkg::*;

  // ****************************************************************
  // Idle levels and requests
  // ****************************************************************
  // Strobe pin rests high, no request pending
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    dac_load_strobe_n = 1'b1;
  end

  // One access, taken at the second edge; released lines change value
  task automatic access(input logic wr, input dlt_byte_t a,
                        input dlt_byte_t d);
    @(posedge clk);
    reg_wr <= wr;
    reg_rd <= ~wr;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask

  // Set the strobe level and keep it three clocks at least
  task automatic strobe(input logic lvl);
    @(posedge clk);
    dac_load_strobe_n <= lvl;
    repeat (3) @(posedge clk);
  endtask
endmodule // dlt_host_model

// File: dlt_pkg.sv
// Types shared by the DAC load and thermal output control block.
// Assumes dlt_consts.svh is on the include path.
package dlt_pkg;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef logic [7:0] dlt_byte_t;
  typedef logic [3:0][7:0] dlt_codes_t;
  typedef logic [9:0] dlt_temp_t;

  // Power-up calibration states, one-hot
  typedef enum logic [1:0] {
    DLT_CAL_RUN = 2'b01,
    DLT_CAL_IDLE = 2'b10
  } dlt_cal_state_t;

endpackage
